// *** mac_dma_status_pkg.sv ***
// constants, register map and decode helper for the dma pointer status block
// How it works
// R1: receive write pointer register pair mirrors live receive dma address, read only
// R2: soft reset or reload bit loads receive pointer from transmit lower boundary
// R3: transmit read pointer register pair mirrors live transmit dma address, read only
// R4: soft reset or reload bit loads transmit pointer from transmit lower boundary
// R5: pointers move in 32-byte granules, so five low bits read zero
// R6: 8 KB buffer keeps upper three bits of each high byte zero
// R7: each 16-bit value is a low byte register and a high byte register
// R8: free block count reports unused packet buffers in the receive region
// R9: free count below buffer size threshold triggers automatic pause frame
// R10: software may read free count and request pause via config four bit 6
// R11: software sizes receive region one buffer larger than largest packet
// R12: cpu writes to these registers change nothing
`default_nettype none
package mac_dma_status_pkg;
  // apb geometry
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  // packet buffer granule and buffer memory size
  localparam int GRANULE_SHIFT = 5;
  localparam int BLK_W         = 8;
  localparam int CNT_W         = 9;
  localparam int NUM_REGS      = 6;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RX_PTR_LOW   = 8'h51;
  localparam logic [7:0] IDX_RX_PTR_HIGH  = 8'h52;
  localparam logic [7:0] IDX_TX_PTR_LOW   = 8'h53;
  localparam logic [7:0] IDX_TX_PTR_HIGH  = 8'h54;
  localparam logic [7:0] IDX_FREE_LOW     = 8'h55;
  localparam logic [7:0] IDX_FREE_HIGH    = 8'h56;
  localparam logic [7:0] REG_IDX [NUM_REGS] = '{IDX_RX_PTR_LOW, IDX_RX_PTR_HIGH, IDX_TX_PTR_LOW,
                                                IDX_TX_PTR_HIGH, IDX_FREE_LOW, IDX_FREE_HIGH};
  // values after reset
  localparam logic [BLK_W-1:0]  RST_BLK  = 8'h00;
  localparam logic [CNT_W-1:0]  RST_FREE = 9'h000;
  localparam logic [APB_DW-1:0] RST_DATA = 32'h0000_0000;

  // returns {hit, slot}; slot is the position in the byte view
  function automatic logic [3:0] reg_decode(input logic [APB_AW-1:0] addr);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr == {2'b00, REG_IDX[i], 2'b00}) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction
endpackage
`default_nettype wire

// *** reg_view_if.sv ***
// byte view of the status registers handed from the core to the bus slave
`default_nettype none
interface reg_view_if;
  import mac_dma_status_pkg::*;
  logic [NUM_REGS-1:0][7:0] bytes;
  modport src  (output bytes);
  modport sink (input  bytes);
endinterface
`default_nettype wire

// *** apb_status_slave.sv ***
// apb slave answering reads from the byte view with one wait state
`default_nettype none
module apb_status_slave
  import mac_dma_status_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // apb
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // register contents
  reg_view_if.sink               view
);
  typedef struct packed {
    logic [APB_DW-1:0] rdata;
    logic              ready;
    logic              err;
  } slave_state_s;

  slave_state_s st;
  slave_state_s next_st;
  logic [3:0]   dec;

  // access phase answered one cycle later; writes are accepted and dropped
  always_comb begin
    dec     = reg_decode(paddr_i);
    next_st = st;
    next_st.ready = 1'b0;
    if (psel_i && penable_i && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.err   = !dec[3];
      next_st.rdata = RST_DATA;
      if (dec[3] && !pwrite_i) begin
        next_st.rdata = {24'h000000, view.bytes[dec[2:0]]}; // R7
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{rdata: RST_DATA, ready: 1'b0, err: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o  = st.rdata;
  assign pready_o  = st.ready;
  assign pslverr_o = st.err;
endmodule
`default_nettype wire

// *** pause_decider.sv ***
// compares free receive blocks with the threshold and raises pause requests
`default_nettype none
module pause_decider
  import mac_dma_status_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // inputs
  input  wire logic [CNT_W-1:0] free_blocks_i,
  input  wire logic [BLK_W-1:0] block_level_i,
  input  wire logic             sw_pause_req_i,
  // outputs
  output logic                  pause_needed_o,
  output logic                  pause_send_o
);
  typedef struct packed {
    logic need;
    logic send;
    logic sw_q;
  } pause_state_s;

  pause_state_s st;
  pause_state_s next_st;

  // one send pulse per crossing so a long shortage does not flood the link
  always_comb begin
    next_st      = st;
    next_st.need = free_blocks_i < {1'b0, block_level_i}; // R9
    next_st.sw_q = sw_pause_req_i;
    next_st.send = (next_st.need && !st.need) || (sw_pause_req_i && !st.sw_q);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{need: 1'b0, send: 1'b0, sw_q: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pause_needed_o = st.need;
  assign pause_send_o   = st.send;
endmodule
`default_nettype wire

// *** mac_dma_pointer_status.sv ***
// dma pointer tracking, free block count and status register view
`default_nettype none
module mac_dma_pointer_status
  import mac_dma_status_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // apb register bus
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [APB_DW-1:0] pwdata_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // reset control bits, boundaries and the rx read pointer
  input  wire logic              soft_reset_bit_i,
  input  wire logic              rx_pointer_reload_bit_i,
  input  wire logic [15:0]       tx_lower_boundary_ptr_i,
  input  wire logic [15:0]       rx_lower_boundary_ptr_i,
  input  wire logic [15:0]       rx_upper_boundary_ptr_i,
  input  wire logic [15:0]       rx_read_ptr_i,
  // dma progress events
  input  wire logic              rx_block_written_i,
  input  wire logic              tx_block_read_i,
  // pause control
  input  wire logic [BLK_W-1:0]  block_level_i,
  input  wire logic              sw_pause_req_i,
  output logic                   pause_needed_o,
  output logic                   pause_send_o,
  // live pointers for the dma engines
  output logic      [15:0]       rx_write_ptr_o,
  output logic      [15:0]       tx_read_ptr_o
);
  typedef struct packed {
    logic [BLK_W-1:0] rx_blk;
    logic [BLK_W-1:0] tx_blk;
    logic [CNT_W-1:0] free;
  } dma_state_s;

  dma_state_s st;
  dma_state_s next_st;

  reg_view_if view ();

  logic             reload;
  logic [BLK_W-1:0] tlb_blk;
  logic [BLK_W-1:0] rlb_blk;
  logic [CNT_W-1:0] rub_end;
  logic [BLK_W-1:0] rrd_blk;
  logic [CNT_W-1:0] region;
  logic [CNT_W-1:0] rx_inc;
  logic [CNT_W-1:0] tx_inc;
  logic [15:0]      rx_addr;
  logic [15:0]      tx_addr;
  logic [15:0]      free16;
  logic [3:0]       bus_dec;

  // pointers kept as granule indices: low five and top three bits stay zero
  assign tlb_blk = tx_lower_boundary_ptr_i[GRANULE_SHIFT +: BLK_W];
  assign rlb_blk = rx_lower_boundary_ptr_i[GRANULE_SHIFT +: BLK_W];
  assign rub_end = rx_upper_boundary_ptr_i[GRANULE_SHIFT +: CNT_W]; // keeps bit 13 for an end at the top
  assign rrd_blk = rx_read_ptr_i[GRANULE_SHIFT +: BLK_W];
  assign reload  = soft_reset_bit_i | rx_pointer_reload_bit_i;
  // same decode as the slave, used by the bus checks below
  assign bus_dec = reg_decode(paddr_i);

  // byte addresses rebuilt from the indices
  assign rx_addr = {3'b000, st.rx_blk, 5'b00000}; // R5 R6
  assign tx_addr = {3'b000, st.tx_blk, 5'b00000}; // R5 R6
  assign free16  = {7'b0000000, st.free};

  // wrap arithmetic done one bit wider so the top granule does not alias
  assign region = rub_end - {1'b0, rlb_blk};
  assign rx_inc = {1'b0, st.rx_blk} + 9'h001;
  assign tx_inc = {1'b0, st.tx_blk} + 9'h001;

  // pointer motion and free count
  always_comb begin
    next_st = st;
    if (reload) begin
      next_st.rx_blk = tlb_blk; // R2
      next_st.tx_blk = tlb_blk; // R4
    end else begin
      if (rx_block_written_i) begin
        next_st.rx_blk = (rx_inc == rub_end) ? rlb_blk : rx_inc[BLK_W-1:0]; // R1
      end
      if (tx_block_read_i) begin
        next_st.tx_blk = (tx_inc == {1'b0, rlb_blk}) ? tlb_blk : tx_inc[BLK_W-1:0]; // R3
      end
    end
    // equal pointers mean the region is empty; correct only while R11 holds
    if (rrd_blk > st.rx_blk) begin
      next_st.free = {1'b0, rrd_blk} - {1'b0, st.rx_blk}; // R8
    end else begin
      next_st.free = region - ({1'b0, st.rx_blk} - {1'b0, rrd_blk}); // R8
    end
  end

  // bus writes are never looked at by the state update
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{rx_blk: RST_BLK, tx_blk: RST_BLK, free: RST_FREE};
    end else begin
      st <= next_st; // R12
    end
  end

  // byte view in register order, low byte then high byte
  assign view.bytes[0] = rx_addr[7:0];   // R7
  assign view.bytes[1] = rx_addr[15:8];  // R7
  assign view.bytes[2] = tx_addr[7:0];   // R7
  assign view.bytes[3] = tx_addr[15:8];  // R7
  assign view.bytes[4] = free16[7:0];    // R7
  assign view.bytes[5] = free16[15:8];   // R7

  // outputs straight from the pointer flops
  assign rx_write_ptr_o = rx_addr;
  assign tx_read_ptr_o  = tx_addr;

  // register bus slave
  apb_status_slave u_slave (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .view      (view.sink)
  );

  // automatic and software pause decisions
  pause_decider u_pause (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .free_blocks_i  (st.free),
    .block_level_i  (block_level_i),
    .sw_pause_req_i (sw_pause_req_i),
    .pause_needed_o (pause_needed_o),
    .pause_send_o   (pause_send_o)
  );

  // write data is deliberately unused: every register here is read only
  logic unused_wdata;
  assign unused_wdata = ^pwdata_i;

  // reload lands on both pointers one cycle later
  property p_rx_reload;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reload |=> rx_write_ptr_o == {3'b000, $past(tx_lower_boundary_ptr_i[12:5]), 5'b00000};
  endproperty
  a_rx_reload: assert property (p_rx_reload) else $error("rx pointer not reloaded"); // R2

  property p_tx_reload;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reload |=> tx_read_ptr_o == {3'b000, $past(tx_lower_boundary_ptr_i[12:5]), 5'b00000};
  endproperty
  a_tx_reload: assert property (p_tx_reload) else $error("tx pointer not reloaded"); // R4

  property p_granule;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_write_ptr_o[4:0] == 5'h00 && tx_read_ptr_o[4:0] == 5'h00;
  endproperty
  a_granule: assert property (p_granule) else $error("pointer low bits not zero"); // R5

  property p_top_bits;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    view.bytes[1][7:5] == 3'h0 && view.bytes[3][7:5] == 3'h0;
  endproperty
  a_top_bits: assert property (p_top_bits) else $error("pointer high byte above 1f"); // R6

  property p_rx_advance;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_block_written_i && !reload && rx_inc != rub_end
      |=> rx_write_ptr_o == $past(rx_write_ptr_o) + 16'h0020;
  endproperty
  a_rx_advance: assert property (p_rx_advance) else $error("rx pointer did not advance"); // R1

  property p_tx_advance;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_block_read_i && !reload && tx_inc != {1'b0, rlb_blk}
      |=> tx_read_ptr_o == $past(tx_read_ptr_o) + 16'h0020;
  endproperty
  a_tx_advance: assert property (p_tx_advance) else $error("tx pointer did not advance"); // R3

  property p_read_data;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == {2'b00, IDX_RX_PTR_LOW, 2'b00}
      && !reload && !rx_block_written_i
      |=> pready_o && prdata_o == {24'h000000, rx_write_ptr_o[7:0]};
  endproperty
  a_read_data: assert property (p_read_data) else $error("low byte read wrong"); // R7

  property p_free_count;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (rrd_blk == st.rx_blk) && $stable(rrd_blk) && $stable(st.rx_blk) && $stable(region)
      |=> free16 == {7'b0000000, $past(region)};
  endproperty
  a_free_count: assert property (p_free_count) else $error("free count wrong when empty"); // R8

  property p_pause;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.free < {1'b0, block_level_i} |=> pause_needed_o;
  endproperty
  a_pause: assert property (p_pause) else $error("pause need not raised"); // R9

  property p_write_ignored;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && pwrite_i && !reload && !rx_block_written_i && !tx_block_read_i
      |=> $stable(rx_write_ptr_o) && $stable(tx_read_ptr_o);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed a pointer"); // R12

  // wrap points: rx returns to its lower boundary, tx to the tx lower boundary
  property p_rx_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_block_written_i && !reload && rx_inc == rub_end
      |=> rx_write_ptr_o == {3'b000, $past(rlb_blk), 5'b00000};
  endproperty
  a_rx_wrap: assert property (p_rx_wrap) else $error("rx pointer did not wrap"); // R1

  property p_tx_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_block_read_i && !reload && tx_inc == {1'b0, rlb_blk}
      |=> tx_read_ptr_o == {3'b000, $past(tlb_blk), 5'b00000};
  endproperty
  a_tx_wrap: assert property (p_tx_wrap) else $error("tx pointer did not wrap"); // R3

  // without an event the pointers stand still
  property p_rx_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !reload && !rx_block_written_i |=> $stable(rx_write_ptr_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx pointer moved without event"); // R1

  property p_tx_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !reload && !tx_block_read_i |=> $stable(tx_read_ptr_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pointer moved without event"); // R3

  // bus answer: one wait state, a single-cycle ready, upper data bits zero
  property p_one_wait;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait"); // R7

  property p_ready_pulse;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle"); // R7

  property p_upper_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pready_o |-> prdata_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero"); // R7

  // writes to mapped registers are answered without error; unmapped ones fail
  property p_write_ok;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o && pwrite_i && bus_dec[3] |=> pready_o && !pslverr_o;
  endproperty
  a_write_ok: assert property (p_write_ok) else $error("write to mapped register refused"); // R12

  property p_unmapped;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o && !bus_dec[3]
      |=> pready_o && pslverr_o && prdata_o == RST_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged"); // R7

  // read data carries the byte as it stood at the edge the access was taken
  property p_free_read;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == {2'b00, IDX_FREE_LOW, 2'b00}
      |=> prdata_o == {24'h000000, $past(free16[7:0])};
  endproperty
  a_free_read: assert property (p_free_read) else $error("free count read wrong"); // R8

  property p_tx_high_read;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == {2'b00, IDX_TX_PTR_HIGH, 2'b00}
      |=> prdata_o == {24'h000000, $past(tx_read_ptr_o[15:8])};
  endproperty
  a_tx_high_read: assert property (p_tx_high_read) else $error("tx high byte read wrong"); // R7

  // a shortage starts one send; enough free blocks clear the need
  property p_send_on_need;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(pause_needed_o) |-> pause_send_o;
  endproperty
  a_send_on_need: assert property (p_send_on_need) else $error("no send when need rose"); // R9

  property p_need_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st.free >= {1'b0, block_level_i} |=> !pause_needed_o;
  endproperty
  a_need_clear: assert property (p_need_clear) else $error("pause need not cleared"); // R9
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the dma pointer status block
`default_nettype none
module testbench
  import mac_dma_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic              soft_rst = 1'b0;
  logic              reload = 1'b0;
  logic [15:0]       tx_lo = 16'h0000;
  logic [15:0]       rx_lo = 16'h0400;
  logic [15:0]       rx_hi = 16'h0800;
  logic [15:0]       rx_rd = 16'h0400;
  logic              rx_wr_ev = 1'b0;
  logic              tx_rd_ev = 1'b0;
  logic [BLK_W-1:0]  level = 8'h00;
  logic              sw_pause = 1'b0;
  logic              pause_needed_o;
  logic              pause_send_o;
  logic [15:0]       rx_write_ptr_o;
  logic [15:0]       tx_read_ptr_o;
  int                num_errors = 0;
  int                check_count = 0;

  // 125 MHz system clock
  always #4 sys_clk_i = ~sys_clk_i;

  mac_dma_pointer_status DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .soft_reset_bit_i(soft_rst), .rx_pointer_reload_bit_i(reload), .tx_lower_boundary_ptr_i(tx_lo),
    .rx_lower_boundary_ptr_i(rx_lo), .rx_upper_boundary_ptr_i(rx_hi), .rx_read_ptr_i(rx_rd),
    .rx_block_written_i(rx_wr_ev), .tx_block_read_i(tx_rd_ev), .block_level_i(level),
    .sw_pause_req_i(sw_pause), .pause_needed_o(pause_needed_o), .pause_send_o(pause_send_o),
    .rx_write_ptr_o(rx_write_ptr_o), .tx_read_ptr_o(tx_read_ptr_o));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; pready, data and error are taken at the same edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [APB_DW-1:0] wd,
                     output logic [APB_DW-1:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check("pready", 1'b0, 1'b1);
      end_of_test();
    end
  endtask

  // read a byte register and compare its low byte, upper bits zero
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [APB_DW-1:0] d;
    logic              e;
    apb(1'b0, idx, '0, d, e);
    check("prdata", d, {24'h0, exp});
    check("pslverr", e, 1'b0);
  endtask

  // one-cycle pulse on a control input, then let the effect settle
  localparam int SEL_SOFT   = 0;
  localparam int SEL_RELOAD = 1;
  localparam int SEL_RX     = 2;
  localparam int SEL_TX     = 3;
  task automatic pulse(input int sel);
    @(posedge sys_clk_i);
    case (sel)
      SEL_SOFT:   soft_rst <= 1'b1;
      SEL_RELOAD: reload <= 1'b1;
      SEL_RX:     rx_wr_ev <= 1'b1;
      default:    tx_rd_ev <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    {soft_rst, reload, rx_wr_ev, tx_rd_ev} <= 4'h0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    logic [APB_DW-1:0] d;
    logic              e;
    // free count is live: read pointer 0x20 ahead of write pointer 0
    for (int i = 0; i < NUM_REGS; i++) rd_chk(REG_IDX[i], (i == 4) ? 8'h20 : 8'h00);
    apb(1'b0, 8'h58, '0, d, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", d, 32'h0);
  endtask

  task automatic t_reload();
    tx_lo <= 16'hffff;
    pulse(SEL_SOFT);
    check("rx ptr", rx_write_ptr_o, 16'h1fe0);
    check("tx ptr", tx_read_ptr_o, 16'h1fe0);
    rd_chk(IDX_RX_PTR_LOW, 8'he0);
    rd_chk(IDX_RX_PTR_HIGH, 8'h1f);
    rd_chk(IDX_TX_PTR_LOW, 8'he0);
    rd_chk(IDX_TX_PTR_HIGH, 8'h1f);
    tx_lo <= 16'h0421;
    pulse(SEL_RELOAD);
    check("rx ptr", rx_write_ptr_o, 16'h0420);
    check("tx ptr", tx_read_ptr_o, 16'h0420);
  endtask

  // rx pointer at read pointer means the whole 32-block region is free
  task automatic t_advance();
    tx_lo <= 16'h0400;
    pulse(SEL_RELOAD);
    rd_chk(IDX_FREE_LOW, 8'h20);
    pulse(SEL_RX);
    check("rx ptr", rx_write_ptr_o, 16'h0420);
    rd_chk(IDX_RX_PTR_LOW, 8'h20);
    rd_chk(IDX_RX_PTR_HIGH, 8'h04);
    rd_chk(IDX_FREE_LOW, 8'h1f);
    rd_chk(IDX_FREE_HIGH, 8'h00);
  endtask

  // count pause_send pulses over a short window
  task automatic sends(input int exp);
    int c;
    c = 0;
    repeat (6) begin
      @(posedge sys_clk_i);
      if (pause_send_o === 1'b1) c++;
    end
    check("pause sends", c, exp);
  endtask

  task automatic t_pause();
    @(posedge sys_clk_i);
    level <= 8'h20;
    sends(1);
    check("need", pause_needed_o, 1'b1);
    level <= 8'h1f;
    repeat (3) @(posedge sys_clk_i);
    check("need strict", pause_needed_o, 1'b0);
    sw_pause <= 1'b1;
    sends(1);
    sw_pause <= 1'b0;
  endtask

  // writes are acknowledged but change nothing
  task automatic t_write();
    logic [APB_DW-1:0] d;
    logic              e;
    apb(1'b1, IDX_RX_PTR_LOW, 32'hffff_ffff, d, e);
    check("write err", e, 1'b0);
    apb(1'b1, IDX_FREE_LOW, 32'h0000_00aa, d, e);
    rd_chk(IDX_RX_PTR_LOW, 8'h20);
    rd_chk(IDX_FREE_LOW, 8'h1f);
    check("rx ptr", rx_write_ptr_o, 16'h0420);
  endtask

  // tx region ends at rx lower boundary, moved up so no wrap occurs
  task automatic t_tx();
    rx_lo <= 16'h1000;
    pulse(SEL_TX);
    check("tx ptr", tx_read_ptr_o, 16'h0420);
    rd_chk(IDX_TX_PTR_LOW, 8'h20);
    rd_chk(IDX_TX_PTR_HIGH, 8'h04);
  endtask

  // small regions so both pointers wrap; free count with read pointer ahead
  task automatic t_wrap();
    rx_lo <= 16'h0400;
    rx_hi <= 16'h0480;
    tx_lo <= 16'h03c0;
    pulse(SEL_RELOAD);
    pulse(SEL_TX);
    pulse(SEL_TX);
    check("tx wrap", tx_read_ptr_o, 16'h03c0);
    tx_lo <= 16'h0400;
    pulse(SEL_RELOAD);
    repeat (4) pulse(SEL_RX);
    check("rx wrap", rx_write_ptr_o, 16'h0400);
    rx_rd <= 16'h0440;
    rd_chk(IDX_FREE_LOW, 8'h02);
    check("need low free", pause_needed_o, 1'b1);
  endtask

  // watchdog sized well beyond the few hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_reload();
    t_advance();
    t_pause();
    t_write();
    t_tx();
    t_wrap();
    end_of_test();
  end
endmodule
`default_nettype wire
